//--- include/conv_cfg_regs.svh
// register offsets, field positions, reset values and timing counts for the conversion configuration block
`ifndef CONV_CFG_REGS_SVH
`define CONV_CFG_REGS_SVH
`define CFG_ADDR_CONVERSION 2'h0
`define CFG_RESET_VALUE 10'h020
`define CFG_BIT_REF_EXT 0
`define CFG_BIT_MODE 1
`define CFG_BIT_POWER_DOWN 2
`define CFG_BIT_SEL_LO 3
`define CFG_BIT_SEL_HI 4
`define CFG_BIT_PAIR_LO 5
`define CFG_BIT_PAIR_HI 6
`define CFG_BIT_SCAN 7
`define CFG_BIT_CHECK_LO 8
`define CFG_BIT_CHECK_HI 9
`define CONV_TIME_NS 200
`define CONV_CYCLES ((`CONV_TIME_NS + 49) / 50)
`endif

//--- include/conv_cfg_pkg.sv
// types shared by the conversion configuration block
package conv_cfg_pkg;
  typedef enum logic [2:0] {
    INPUT_AP = 3'h0,
    INPUT_AM = 3'h1,
    INPUT_BP = 3'h2,
    INPUT_BM = 3'h3,
    INPUT_DA = 3'h4,
    INPUT_DB = 3'h5
  } input_t;

  typedef enum logic [1:0] {
    CHECK_NONE = 2'h0,
    CHECK_UPPER = 2'h1,
    CHECK_MID = 2'h2,
    CHECK_LOWER = 2'h3
  } check_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_STORE = 3'h4
  } conv_state_t;

  typedef struct packed {
    logic [1:0] check_level_sel;
    logic scan;
    logic [1:0] pair_count;
    logic [1:0] input_select;
    logic power_down;
    logic single_mode;
    logic ref_external;
  } conversion_config_t;

  typedef struct packed {
    logic valid;
    logic [2:0] input_id;
    logic [1:0] check;
  } conv_request_t;
endpackage

//--- rtl/scan_sequencer.sv
// scan sequence table: which input comes at which step, and how long each sequence is
`timescale 1ns/10ps
`default_nettype none
module scan_sequencer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // selection
  input wire logic scan,
  input wire logic [1:0] pair_count,
  input wire logic [1:0] input_select,
  input wire logic [1:0] step,
  // answer
  output logic [2:0] input_id,
  output logic [1:0] last_step,
  output logic legal
);
  logic [2:0] next_input_id;
  logic [1:0] next_last_step;
  logic next_legal;

  always_comb begin
    next_input_id = 3'(conv_cfg_pkg::INPUT_AP);
    next_last_step = 2'h0;
    next_legal = 1'b1;
    case ({scan, pair_count, input_select})
      5'h00: next_input_id = 3'(conv_cfg_pkg::INPUT_AP);
      5'h01: next_input_id = 3'(conv_cfg_pkg::INPUT_AM);
      5'h02: next_input_id = 3'(conv_cfg_pkg::INPUT_BP);
      5'h03: next_input_id = 3'(conv_cfg_pkg::INPUT_BM);
      5'h04: next_input_id = 3'(conv_cfg_pkg::INPUT_DA);
      5'h05: next_input_id = 3'(conv_cfg_pkg::INPUT_DB);
      5'h11: begin
        next_last_step = 2'h1;
        next_input_id = (step == 2'h0) ? 3'(conv_cfg_pkg::INPUT_AP) : 3'(conv_cfg_pkg::INPUT_AM);
      end
      5'h12, 5'h13: begin
        next_last_step = (input_select == 2'h3) ? 2'h3 : 2'h2;
        next_input_id = {1'b0, step};
      end
      5'h15: begin
        next_last_step = 2'h1;
        next_input_id = (step == 2'h0) ? 3'(conv_cfg_pkg::INPUT_AP) : 3'(conv_cfg_pkg::INPUT_DB);
      end
      5'h16: begin
        next_last_step = 2'h2;
        next_input_id = (step == 2'h2) ? 3'(conv_cfg_pkg::INPUT_DB) : {1'b0, step};
      end
      5'h19: begin
        next_last_step = 2'h1;
        next_input_id = (step == 2'h0) ? 3'(conv_cfg_pkg::INPUT_DA) : 3'(conv_cfg_pkg::INPUT_DB);
      end
      // reserved codes fall back to a single input and are flagged
      default: next_legal = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      input_id <= 3'h0;
      last_step <= 2'h0;
      legal <= 1'b1;
    end else begin
      input_id <= next_input_id;
      last_step <= next_last_step;
      legal <= next_legal;
    end
  end
endmodule
`default_nettype wire

//--- rtl/conversion_config.sv
// conversion configuration register and the conversion pacing it steers
// Operation
// - bit 0 picks internal reference when clear, external reference when set; resets clear.
// - bit 1 clear, the reset value, means continuous conversion paced by sample clock.
// - continuous mode stores one result per falling edge of the free-running sample clock.
// - bit 1 set makes the sample clock pin a single-shot trigger.
// - trigger falling edge holds all selected inputs together, then converts them in turn.
// - single mode raises the ready flag when stored results reach the trigger level.
// - bit 2 set powers the converter down; clear keeps it active; resets clear.
// - register writes and reads keep working while powered down.
// - results already stored stay readable while powered down.
// - bits 3 and 4 choose the input or input pair converted; reset clear.
// - bits 5 and 6 give the differential count; reset has bit 5 set.
// - bit 7 enables automatic scanning; resets clear.
// - bits 8 and 9 choose a test voltage instead of the input; reset clear.
// - test code 0 normal, 1 upper, 2 midpoint, 3 lower reference.
// - four-input scan converts the inputs in fixed repeating order into storage.
// - trigger met once trigger-level results are stored since the previous trigger.
`timescale 1ns/10ps
`default_nettype none
`include "conv_cfg_regs.svh"
module conversion_config #(
  parameter int TRIGGER_LEVEL = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // parallel data bus
  input wire logic [11:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [9:0] bus_rdata,
  // conversion pacing pin
  input wire logic sample_clock_in,
  // results drained by the storage logic outside
  input wire logic result_taken,
  // conversion control toward the analog core
  output var conv_cfg_pkg::conv_request_t conv_request,
  output logic sample_hold,
  output logic ref_external,
  output logic analog_power_down,
  output logic block_ready_flag,
  output logic config_reserved
);
  initial begin
    if (TRIGGER_LEVEL < 1 || TRIGGER_LEVEL > 14) begin
      $error("TRIGGER_LEVEL must be 1 to 14");
    end
    if (`CONV_CYCLES < 1 || `CONV_CYCLES > 15) begin
      $error("conversion time must give 1 to 15 cycles");
    end
  end

  localparam logic [3:0] TRIG_LEVEL = 4'(TRIGGER_LEVEL);
  localparam logic [3:0] CONV_COUNT = 4'(`CONV_CYCLES);

  conv_cfg_pkg::conversion_config_t cfg;
  conv_cfg_pkg::conv_state_t state;
  logic pin_prev;
  logic [1:0] step;
  logic [2:0] seq_input;
  logic [1:0] seq_last;
  logic seq_legal;
  logic [3:0] conv_timer;
  logic [3:0] stored_count;
  logic cfg_hit;
  logic pin_fall;
  logic store_now;

  assign cfg_hit = bus_write && (bus_wdata[11:10] == `CFG_ADDR_CONVERSION);
  assign pin_fall = pin_prev && !sample_clock_in;
  assign store_now = (state == conv_cfg_pkg::ST_STORE);

  // register write stays live in power down
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg <= conv_cfg_pkg::conversion_config_t'(`CFG_RESET_VALUE);
    end else if (cfg_hit) begin
      cfg <= conv_cfg_pkg::conversion_config_t'(bus_wdata[9:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata <= 10'h000;
    end else if (bus_read) begin
      bus_rdata <= cfg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= sample_clock_in;
    end
  end

  scan_sequencer u_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .scan(cfg.scan),
    .pair_count(cfg.pair_count),
    .input_select(cfg.input_select),
    .step(step),
    .input_id(seq_input),
    .last_step(seq_last),
    .legal(seq_legal)
  );

  // conversion sequencer; power down only stops new conversions
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= conv_cfg_pkg::ST_IDLE;
      step <= 2'h0;
      conv_timer <= 4'h0;
    end else begin
      case (state)
        conv_cfg_pkg::ST_IDLE: begin
          // continuous scans resume where they stopped; a write or a single shot restarts them
          if (cfg.single_mode || cfg_hit) begin
            step <= 2'h0;
          end
          if (pin_fall && !cfg.power_down) begin
            conv_timer <= CONV_COUNT;
            state <= cfg.single_mode ? conv_cfg_pkg::ST_CONV : conv_cfg_pkg::ST_STORE;
          end
        end
        conv_cfg_pkg::ST_CONV: begin
          if (conv_timer <= 4'h1) begin
            state <= conv_cfg_pkg::ST_STORE;
          end else begin
            conv_timer <= conv_timer - 4'h1;
          end
        end
        conv_cfg_pkg::ST_STORE: begin
          if (cfg.single_mode && step != seq_last) begin
            step <= step + 2'h1;
            conv_timer <= CONV_COUNT;
            state <= conv_cfg_pkg::ST_CONV;
          end else begin
            // continuous mode advances the scan one input per sample edge
            if (!cfg.single_mode) begin
              step <= (step == seq_last) ? 2'h0 : step + 2'h1;
            end
            state <= conv_cfg_pkg::ST_IDLE;
          end
        end
        default: state <= conv_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sample_hold <= 1'b0;
    end else if (pin_fall && cfg.single_mode && !cfg.power_down && state == conv_cfg_pkg::ST_IDLE) begin
      sample_hold <= 1'b1;
    end else if (store_now && step == seq_last) begin
      sample_hold <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_request <= '0;
    end else begin
      conv_request.valid <= store_now;
      conv_request.input_id <= seq_input;
      conv_request.check <= cfg.check_level_sel;
    end
  end

  // trigger counter; results already stored are untouched by power down
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stored_count <= 4'h0;
      block_ready_flag <= 1'b0;
    end else begin
      block_ready_flag <= 1'b0;
      if (store_now) begin
        if (stored_count + 4'h1 >= TRIG_LEVEL) begin
          stored_count <= 4'h0;
          block_ready_flag <= cfg.single_mode;
        end else begin
          stored_count <= stored_count + 4'h1;
        end
      end
      // a drain in the same cycle as a new trigger must not swallow it
      if (result_taken && !store_now) begin
        block_ready_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ref_external <= 1'b0;
      analog_power_down <= 1'b0;
      config_reserved <= 1'b0;
    end else begin
      ref_external <= cfg.ref_external;
      analog_power_down <= cfg.power_down;
      config_reserved <= !seq_legal;
    end
  end

  // checks on the register, the sequencer and the registered outputs
  AST_RESET_VALUE: assert property (@(posedge sys_clk) sys_rst |=> cfg == `CFG_RESET_VALUE)
    else $error("config not at reset value");

  AST_WRITE_TAKES: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cfg_hit |=> cfg == $past(bus_wdata[9:0]))
    else $error("config write lost");

  AST_OTHER_ADDR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bus_write && bus_wdata[11:10] != `CFG_ADDR_CONVERSION) |=> $stable(cfg))
    else $error("write to other address changed config");

  AST_PD_NO_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfg.power_down && state == conv_cfg_pkg::ST_IDLE) |=> state == conv_cfg_pkg::ST_IDLE)
    else $error("conversion started in power down");

  AST_CONT_STORE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pin_fall && !cfg.single_mode && !cfg.power_down && state == conv_cfg_pkg::ST_IDLE && !cfg_hit)
    |=> ##1 conv_request.valid)
    else $error("continuous edge stored no result");

  AST_SINGLE_CONV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pin_fall && cfg.single_mode && !cfg.power_down && state == conv_cfg_pkg::ST_IDLE)
    |=> sample_hold && state == conv_cfg_pkg::ST_CONV)
    else $error("trigger did not hold and convert");

  AST_READY_ONLY_SINGLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    block_ready_flag |-> $past(cfg.single_mode))
    else $error("ready flag outside single mode");

  AST_READBACK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bus_read && !$past(cfg_hit)) |=> bus_rdata == $past(cfg))
    else $error("readback wrong");

  AST_REF_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 ref_external == $past(cfg.ref_external))
    else $error("reference select not followed");

  AST_CHECK_PASS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    store_now |=> conv_request.valid && conv_request.check == $past(cfg.check_level_sel))
    else $error("test level not passed with the result");

  AST_INPUT_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    store_now |=> conv_request.input_id == $past(seq_input))
    else $error("result tagged with the wrong input");

  AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv_request.valid |=> !conv_request.valid)
    else $error("result strobe longer than one cycle");

  AST_CONT_STEP_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == conv_cfg_pkg::ST_IDLE && !cfg.single_mode && !cfg_hit) |=> $stable(step))
    else $error("continuous scan position lost while idle");

  AST_SCAN_WRAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (store_now && !cfg.single_mode && step == seq_last) |=> step == 2'h0)
    else $error("continuous scan did not wrap");

  AST_SINGLE_RESTART: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == conv_cfg_pkg::ST_IDLE && cfg.single_mode) |=> step == 2'h0)
    else $error("single shot did not restart the scan");

  AST_SINGLE_NEXT_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (store_now && cfg.single_mode && step != seq_last)
    |=> state == conv_cfg_pkg::ST_CONV && step == $past(step) + 2'h1)
    else $error("single shot did not move to the next input");

  AST_HOLD_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (store_now && step == seq_last) |=> !sample_hold)
    else $error("hold not released after the last input");

  AST_TIMER_RANGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == conv_cfg_pkg::ST_CONV |-> conv_timer != 4'h0 && conv_timer <= CONV_COUNT)
    else $error("conversion timer out of range");

  AST_STORE_AFTER_CONV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == conv_cfg_pkg::ST_CONV && conv_timer <= 4'h1) |=> store_now)
    else $error("finished conversion not stored");

  AST_READY_AT_LEVEL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    block_ready_flag |-> $past(store_now) && $past(stored_count) + 4'h1 >= TRIG_LEVEL)
    else $error("ready flag before the trigger level");

  AST_PD_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 analog_power_down == $past(cfg.power_down))
    else $error("power down not followed");

  AST_RESERVED_FOLLOW: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 config_reserved == !$past(seq_legal))
    else $error("reserved flag not followed");

  AST_READ_HOLDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bus_read |=> $stable(bus_rdata))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

//--- sim/host_model.sv
// host-side model: parallel bus writes and reads, pacing pin and result drain
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic sys_clk,
  // parallel bus
  output logic [11:0] bus_wdata,
  output logic bus_write,
  output logic bus_read,
  input wire logic [9:0] bus_rdata,
  // pacing pin and drain
  output logic sample_clock_in,
  output logic result_taken
);
  initial begin
    bus_wdata = 12'h000;
    bus_write = 1'b0;
    bus_read = 1'b0;
    sample_clock_in = 1'b0;
    result_taken = 1'b0;
  end
  task automatic put(input logic [1:0] addr, input logic [9:0] value);
    @(posedge sys_clk);
    bus_wdata <= {addr, value};
    bus_write <= 1'b1;
    @(posedge sys_clk);
    bus_write <= 1'b0;
    // a released bus does not keep showing the last value
    bus_wdata <= ~{addr, value};
  endtask
  task automatic get(output logic [9:0] value);
    @(posedge sys_clk);
    bus_read <= 1'b1;
    @(posedge sys_clk);
    bus_read <= 1'b0;
    @(posedge sys_clk);
    #1 value = bus_rdata;
  endtask
  // pin rests low between pulses; the falling edge is what counts
  task automatic pulse();
    @(posedge sys_clk);
    sample_clock_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sample_clock_in <= 1'b0;
  endtask
  task automatic take();
    @(posedge sys_clk);
    result_taken <= 1'b1;
    @(posedge sys_clk);
    result_taken <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/conversion_config_bench.sv
// self-checking bench for the conversion configuration block
`timescale 1ns/10ps
`default_nettype none
module conversion_config_bench;
  logic sys_clk, sys_rst, bus_write, bus_read, sample_clock_in, result_taken;
  logic [11:0] bus_wdata;
  logic [9:0] bus_rdata, r;
  conv_cfg_pkg::conv_request_t conv_request;
  logic sample_hold, ref_external, analog_power_down, block_ready_flag, config_reserved;
  int n_fail = 0;
  int comparisons = 0;
  int n, rdy;
  logic [11:0] ids;
  logic [1:0] chk;
  logic hold;
  // value written, then expected {ref_external, analog_power_down, config_reserved}
  logic [12:0] rows [8] = '{{10'h001, 3'b100}, {10'h004, 3'b010}, {10'h018, 3'b000}, {10'h030, 3'b001},
    {10'h098, 3'b000}, {10'h080, 3'b001}, {10'h0E0, 3'b001}, {10'h3A8, 3'b000}};

  conversion_config #(.TRIGGER_LEVEL(4)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .sample_clock_in(sample_clock_in),
    .result_taken(result_taken), .conv_request(conv_request), .sample_hold(sample_hold),
    .ref_external(ref_external), .analog_power_down(analog_power_down), .block_ready_flag(block_ready_flag),
    .config_reserved(config_reserved));
  host_model host (.sys_clk(sys_clk), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .sample_clock_in(sample_clock_in), .result_taken(result_taken));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic collect(input int limit);
    n = 0; ids = 12'h000; rdy = 0; hold = 1'b0; chk = 2'h0;
    repeat (limit) begin
      @(posedge sys_clk);
      #1;
      if (sample_hold === 1'b1) hold = 1'b1;
      if (block_ready_flag === 1'b1) rdy++;
      if (conv_request.valid === 1'b1) begin
        ids = {ids[8:0], conv_request.input_id};
        chk = conv_request.check;
        n++;
      end
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({ref_external, analog_power_down, config_reserved, sample_hold, block_ready_flag}, 5'h00);
    host.get(r);
    check(r, 10'h020);
    $display("reset test done");
    foreach (rows[i]) begin
      host.put(2'h0, rows[i][12:3]);
      host.get(r);
      check(r, rows[i][12:3]);
      check({ref_external, analog_power_down, config_reserved}, rows[i][2:0]);
    end
    $display("table test done");
    // writes to the other addresses must leave the register alone
    for (int a = 1; a < 4; a++) begin
      host.put(a[1:0], 10'h3FF);
      host.get(r);
      check(r, 10'h3A8);
    end
    $display("address test done");
    for (int k = 0; k < 4; k++) begin
      host.put(2'h0, {k[1:0], 8'h00});
      host.pulse();
      collect(12);
      check(n, 1);
      check(ids[2:0], 3'h0);
      check(chk, k[1:0]);
      check(rdy, 0);
    end
    $display("continuous test done");
    // continuous four-input scan keeps its place between sample edges and wraps
    host.put(2'h0, 10'h098);
    for (int j = 0; j < 5; j++) begin
      host.pulse();
      collect(4);
      check(n, 1);
      check(ids[2:0], {1'b0, j[1:0]});
    end
    $display("continuous scan test done");
    host.put(2'h0, 10'h09A);
    repeat (2) begin
      host.pulse();
      collect(40);
      check(ids, 12'h053);
      check(hold, 1'b1);
      check(rdy, 1);
      host.take();
    end
    $display("single scan test done");
    host.put(2'h0, 10'h006);
    host.pulse();
    collect(40);
    check(n, 0);
    check(hold, 1'b0);
    host.get(r);
    check(r, 10'h006);
    check(analog_power_down, 1'b1);
    $display("power down test done");
    // reset in mid-run must bring back the reset value over a non-default setting
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({analog_power_down, sample_hold, block_ready_flag}, 3'h0);
    host.get(r);
    check(r, 10'h020);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
